// *** design/rafc_regen_avoid.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "rafc_regs.svh"

module rafc_regen_avoid
#(
  parameter int CTRL_CYCLES = `RAFC_CTRL_US * `RAFC_CLK_MHZ
)
(
  input  wire logic                 mclk,
  input  wire logic                 resetn,
  input  wire logic                 highVoltClass,
  input  wire rafc_pkg::rafc_wr_s   settingWr,
  input  wire logic                 extendedParamVisibility,
  input  wire rafc_pkg::rafc_drive_s drive,
  input  wire logic [15:0]          maxOutputFrequency,
  input  wire logic                 overloadOtherCond,
  input  wire logic [7:0]           overloadSignalTimer,
  output logic                      settingAck,
  output logic                      settingRefused,
  output logic [15:0]               compFreq,
  output logic                      regenActive,
  output logic                      stallPrevention,
  output logic                      overloadAlarmSignal,
  output logic [1:0]                regenAvoidSelect,
  output logic [9:0]                regenAvoidLevel,
  output logic [15:0]               compFreqLimit,
  output logic [7:0]                voltageResponseGain,
  output logic [7:0]                frequencyResponseGain
);

  // ---------------------------------------------------------------
  // settings
  // ---------------------------------------------------------------
  logic [1:0]  mode_reg,  mode_next;
  logic [9:0]  level_reg, level_next;
  logic [15:0] limit_reg, limit_next;
  logic [7:0]  vgain_reg, vgain_next;
  logic [7:0]  fgain_reg, fgain_next;
  logic        wrOk;

  function automatic logic in_range(input logic [2:0] sel,
                                    input logic [15:0] d);
    case (sel)
      `RAFC_SEL_MODE:  in_range = d <= 16'(`RAFC_MODE_MAX);
      `RAFC_SEL_LEVEL: in_range = d >= 16'(`RAFC_LEVEL_MIN) &&
                                  d <= 16'(`RAFC_LEVEL_MAX);
      `RAFC_SEL_LIMIT: in_range = d <= `RAFC_LIMIT_MAX ||
                                  d == `RAFC_LIMIT_NONE;
      `RAFC_SEL_VGAIN,
      `RAFC_SEL_FGAIN: in_range = d <= 16'(`RAFC_GAIN_MAX);
      default:         in_range = 1'b0;
    endcase
  endfunction

  always_comb
  begin
    mode_next  = mode_reg;
    level_next = level_reg;
    limit_next = limit_reg;
    vgain_next = vgain_reg;
    fgain_next = fgain_reg;
    // writes are ignored while the extended settings are hidden
    wrOk = settingWr.valid && in_range(settingWr.sel, settingWr.data) &&
           extendedParamVisibility == `RAFC_VIS_ALLOWED;
    if (wrOk)
    begin
      case (settingWr.sel)
        `RAFC_SEL_MODE:  mode_next  = settingWr.data[1:0];
        `RAFC_SEL_LEVEL: level_next = settingWr.data[9:0];
        `RAFC_SEL_LIMIT: limit_next = settingWr.data;
        `RAFC_SEL_VGAIN: vgain_next = settingWr.data[7:0];
        `RAFC_SEL_FGAIN: fgain_next = settingWr.data[7:0];
        default:         mode_next  = mode_reg;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      mode_reg  <= `RAFC_MODE_RST;
      // class strap is caught by the synchronous reset itself
      level_reg <= highVoltClass ? `RAFC_LEVEL_RST_HV
                                 : `RAFC_LEVEL_RST_LV;
      limit_reg <= `RAFC_LIMIT_RST;
      vgain_reg <= `RAFC_GAIN_RST;
      fgain_reg <= `RAFC_GAIN_RST;
    end
    else
    begin
      mode_reg  <= mode_next;
      level_reg <= level_next;
      limit_reg <= limit_next;
      vgain_reg <= vgain_next;
      fgain_reg <= fgain_next;
    end
  end

  assign settingAck            = wrOk;
  assign settingRefused        = settingWr.valid && !wrOk;
  assign regenAvoidSelect      = mode_reg;
  assign regenAvoidLevel       = level_reg;
  assign compFreqLimit         = limit_reg;
  assign voltageResponseGain   = vgain_reg;
  assign frequencyResponseGain = fgain_reg;

  // ---------------------------------------------------------------
  // control tick divider
  // ---------------------------------------------------------------
  logic [15:0] div_reg, div_next;
  logic        tick;

  always_comb
  begin
    tick     = div_reg == 16'(CTRL_CYCLES - 1);
    div_next = tick ? 16'h0000 : div_reg + 16'h0001;
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
      div_reg <= 16'h0000;
    else
      div_reg <= div_next;
  end

  // ---------------------------------------------------------------
  // compensation loop
  // ---------------------------------------------------------------
  rafc_pkg::rafc_state_e state_reg, state_next;
  logic [15:0] comp_reg, comp_next;
  logic [15:0] out_reg, out_next;
  logic        enabled, acting, noCap, decel;
  logic [9:0]  excess;
  logic [31:0] incWide;
  logic [15:0] inc, capped;
  logic [16:0] sum;

  always_comb
  begin
    decel   = drive.ramp == rafc_pkg::RAMP_DECEL;
    enabled = mode_reg == 2'h1 ||
              (mode_reg == 2'h2 && drive.ramp == rafc_pkg::RAMP_CONST);
    acting  = enabled && drive.busVolts >= level_reg;
    excess  = acting ? drive.busVolts - level_reg : 10'h000;
    // gains multiply, so either one at zero leaves only the minimum step of 1 per tick
    incWide = 32'(excess) * 32'(vgain_reg) * 32'(fgain_reg)
              / `RAFC_GAIN_SCALE;
    inc     = (incWide > 32'h0000ffff) ? 16'hffff : incWide[15:0];
    if (acting && inc == 16'h0000)
      inc = 16'h0001;
    noCap   = limit_reg == `RAFC_LIMIT_NONE;
    capped  = comp_reg;
    comp_next  = comp_reg;
    state_next = state_reg;
    case (state_reg)
      rafc_pkg::ST_IDLE:
      begin
        if (acting)
          state_next = rafc_pkg::ST_ACT;
      end
      rafc_pkg::ST_ACT:
      begin
        if (!noCap && decel && comp_reg >= limit_reg)
          state_next = rafc_pkg::ST_HOLD;
        else if (!acting && comp_reg == 16'h0000)
          state_next = rafc_pkg::ST_IDLE;
      end
      rafc_pkg::ST_HOLD:
      begin
        if (drive.preFreq <= (limit_reg >> 1) || noCap ||
            mode_reg == 2'h0)
          state_next = rafc_pkg::ST_ACT;
      end
      default:
        state_next = rafc_pkg::ST_IDLE;
    endcase
    if (tick)
    begin
      if (mode_reg == 2'h0)
        capped = 16'h0000;
      else if (state_reg == rafc_pkg::ST_HOLD)
        capped = limit_reg;
      else if (acting)
        capped = (comp_reg > 16'hffff - inc) ? 16'hffff
                                             : comp_reg + inc;
      else if (comp_reg >= `RAFC_DECAY_STEP)
        capped = comp_reg - `RAFC_DECAY_STEP;
      else
        capped = 16'h0000;
      if (!noCap && state_reg != rafc_pkg::ST_HOLD &&
          capped > limit_reg)
        capped = limit_reg;
      comp_next = capped;
    end
    sum = {1'b0, drive.preFreq} + {1'b0, comp_reg};
    out_next = (sum > {1'b0, maxOutputFrequency}) ? maxOutputFrequency
                                                  : sum[15:0];
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      state_reg <= rafc_pkg::ST_IDLE;
      comp_reg  <= 16'h0000;
      out_reg   <= 16'h0000;
    end
    else
    begin
      state_reg <= state_next;
      comp_reg  <= comp_next;
      out_reg   <= out_next;
    end
  end

  assign compFreq = out_reg;

  // ---------------------------------------------------------------
  // stall prevention and overload alarm
  // ---------------------------------------------------------------
  logic        act_reg, act_next;
  logic        ol_reg, ol_next;
  logic [23:0] olCnt_reg, olCnt_next;
  logic        olCond;
  logic [23:0] olTarget;

  always_comb
  begin
    act_next = acting;
    // overvoltage stall counts as an overload item while acting
    olCond   = overloadOtherCond || act_reg;
    olTarget = 24'(overloadSignalTimer) * 24'(`RAFC_OL_MS_PER_LSB)
               * 24'(CTRL_CYCLES / CTRL_CYCLES);
    olCnt_next = olCnt_reg;
    ol_next    = ol_reg;
    if (!olCond)
    begin
      olCnt_next = 24'h000000;
      ol_next    = 1'b0;
    end
    else if (olCnt_reg >= olTarget)
      ol_next = 1'b1;
    else if (tick)
      olCnt_next = olCnt_reg + 24'h000001;
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      act_reg   <= 1'b0;
      ol_reg    <= 1'b0;
      olCnt_reg <= 24'h000000;
    end
    else
    begin
      act_reg   <= act_next;
      ol_reg    <= ol_next;
      olCnt_reg <= olCnt_next;
    end
  end

  assign regenActive         = act_reg;
  assign stallPrevention     = act_reg;
  assign overloadAlarmSignal = ol_reg;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_mode_off_clear: assert property (@(posedge mclk) disable iff (!resetn)
    mode_reg == 2'h0 && tick |=> comp_reg == 16'h0000)
    else $error("compensation not cleared with mode off");

  a_level_trigger: assert property (@(posedge mclk) disable iff (!resetn)
    enabled && drive.busVolts >= level_reg |=> regenActive)
    else $error("avoidance did not engage at level");

  a_level_range: assert property (@(posedge mclk) disable iff (!resetn)
    level_reg >= `RAFC_LEVEL_MIN && level_reg <= `RAFC_LEVEL_MAX)
    else $error("operation level out of range");

  a_cap_limit: assert property (@(posedge mclk) disable iff (!resetn)
    limit_reg != `RAFC_LIMIT_NONE && state_reg == rafc_pkg::ST_ACT
    |-> comp_reg <= limit_reg)
    else $error("compensation above limit");

  a_hold_value: assert property (@(posedge mclk) disable iff (!resetn)
    state_reg == rafc_pkg::ST_HOLD && tick && mode_reg != 2'h0
    |=> comp_reg == $past(limit_reg))
    else $error("hold does not keep limit value");

  a_max_clamp: assert property (@(posedge mclk) disable iff (!resetn)
    1'b1 |=> compFreq <= $past(maxOutputFrequency))
    else $error("output above maximum frequency");

  a_gain_range: assert property (@(posedge mclk) disable iff (!resetn)
    vgain_reg <= `RAFC_GAIN_MAX && fgain_reg <= `RAFC_GAIN_MAX)
    else $error("gain out of range");

  a_stall_follow: assert property (@(posedge mclk) disable iff (!resetn)
    stallPrevention == regenActive &&
    (regenActive == $past(acting)))
    else $error("stall prevention not tied to avoidance");

  a_ol_drop: assert property (@(posedge mclk) disable iff (!resetn)
    !overloadOtherCond && !regenActive |=> !overloadAlarmSignal)
    else $error("overload alarm without cause");

  a_write_lock: assert property (@(posedge mclk) disable iff (!resetn)
    extendedParamVisibility != `RAFC_VIS_ALLOWED
    |=> $stable(mode_reg) && $stable(level_reg) && $stable(limit_reg))
    else $error("setting changed while locked");

  a_no_excess: assert property (@(posedge mclk) disable iff (!resetn)
    !acting |-> excess == 10'h000)
    else $error("increment without excess");

endmodule

`default_nettype wire

// *** pkg/rafc_regs.svh ***
`ifndef RAFC_REGS_SVH
`define RAFC_REGS_SVH

// ---------------------------------------------------------------
// setting selectors for the write port
// ---------------------------------------------------------------
`define RAFC_SEL_MODE    3'h0
`define RAFC_SEL_LEVEL   3'h1
`define RAFC_SEL_LIMIT   3'h2
`define RAFC_SEL_VGAIN   3'h3
`define RAFC_SEL_FGAIN   3'h4

// ---------------------------------------------------------------
// ranges and reset values (volts, 0.01 Hz, percent)
// ---------------------------------------------------------------
`define RAFC_MODE_MAX      2'h2
`define RAFC_MODE_RST      2'h0
`define RAFC_LEVEL_MIN     10'h12c
`define RAFC_LEVEL_MAX     10'h320
`define RAFC_LEVEL_RST_LV  10'h190
`define RAFC_LEVEL_RST_HV  10'h30c
`define RAFC_LIMIT_MAX     16'h03e8
`define RAFC_LIMIT_RST     16'h0258
`define RAFC_LIMIT_NONE    16'h270f
`define RAFC_GAIN_MAX      8'hc8
`define RAFC_GAIN_RST      8'h64
`define RAFC_GAIN_SCALE    32'd10000
`define RAFC_DECAY_STEP    16'h0001
`define RAFC_VIS_ALLOWED   1'b0

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define RAFC_CLK_MHZ       10
`define RAFC_CTRL_US       1000
`define RAFC_OL_MS_PER_LSB 16'h0064

`endif

// *** pkg/rafc_pkg.sv ***
package rafc_pkg;

  typedef enum logic [2:0]
  {
    RAMP_ACCEL = 3'b001,
    RAMP_CONST = 3'b010,
    RAMP_DECEL = 3'b100
  } rafc_ramp_e;

  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b001,
    ST_ACT  = 3'b010,
    ST_HOLD = 3'b100
  } rafc_state_e;

  typedef struct packed
  {
    logic        valid;
    logic [2:0]  sel;
    logic [15:0] data;
  } rafc_wr_s;

  typedef struct packed
  {
    logic [9:0]  busVolts;
    logic [15:0] preFreq;
    rafc_ramp_e  ramp;
  } rafc_drive_s;

endpackage

// *** test/rafc_drive_model.sv ***
`timescale 1ns/10ps
`default_nettype none

module rafc_drive_model
#(
  parameter logic [9:0]  NOM_V = 10'h137,
  parameter logic [15:0] STEP  = 16'h000a
)
(
  input  wire logic             mclk,
  input  wire logic             resetn,
  input  wire logic [15:0]      target,
  input  wire logic [9:0]       rise,
  output var rafc_pkg::rafc_drive_s drive
);
  logic [15:0] freqReg;
  logic [15:0] freqNext;

  // ------------------
  // frequency ramp
  // ------------------
  always_comb
  begin
    if (freqReg + STEP < target)
      freqNext = freqReg + STEP;
    else if (freqReg > target + STEP)
      freqNext = freqReg - STEP;
    else
      freqNext = target;
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
      freqReg <= 16'h0000;
    else
      freqReg <= freqNext;
  end

  // ------------------
  // bus measurement
  // ------------------
  // nominal bus stays below every level the bench sets, so only the
  // injected rise can engage avoidance
  always_comb
  begin
    drive.busVolts = NOM_V + rise;
    drive.preFreq  = freqReg;
    drive.ramp     = (freqReg < target) ? rafc_pkg::RAMP_ACCEL :
                     (freqReg > target) ? rafc_pkg::RAMP_DECEL :
                     rafc_pkg::RAMP_CONST;
  end
endmodule

`default_nettype wire

// *** test/rafc_regen_avoid_tb.sv ***
`timescale 1ns/10ps
`default_nettype none

module rafc_regen_avoid_tb;
  typedef struct packed
  {
    logic        vis;
    logic [2:0]  sel;
    logic [15:0] data;
    logic        ack;
    logic [15:0] val;
  } rafc_row_s;

  logic                  mclk;
  logic                  resetn;
  logic                  hvClass;
  rafc_pkg::rafc_wr_s    wr;
  logic                  vis;
  rafc_pkg::rafc_drive_s drive;
  logic [15:0]           maxFreq;
  logic [7:0]            olTimer;
  logic                  olOther;
  logic [15:0]           target;
  logic [9:0]            rise;
  logic                  ack;
  logic                  refused;
  logic [15:0]           compFreq;
  logic                  active;
  logic                  stall;
  logic                  alarm;
  logic [1:0]            mode;
  logic [9:0]            level;
  logic [15:0]           limit;
  logic [7:0]            vGain;
  logic [7:0]            fGain;
  int                    numErrors;
  int                    compares;
  logic [15:0]           c0;
  rafc_row_s             rows [15] = '{
    '{0,0,2,1,2}, '{0,0,3,0,2}, '{0,1,299,0,400}, '{0,1,800,1,800},
    '{0,1,801,0,800}, '{0,2,1001,0,600}, '{0,2,9999,1,9999},
    '{0,3,201,0,100}, '{0,4,0,1,0}, '{1,1,350,0,800}, '{0,5,1,0,0},
    '{0,1,350,1,350}, '{0,2,600,1,600}, '{0,4,100,1,100}, '{0,0,1,1,1}};

  rafc_regen_avoid #(.CTRL_CYCLES(4)) dut
  (
    .mclk(mclk),
    .resetn(resetn),
    .highVoltClass(hvClass),
    .settingWr(wr),
    .extendedParamVisibility(vis),
    .drive(drive),
    .maxOutputFrequency(maxFreq),
    .overloadOtherCond(olOther),
    .overloadSignalTimer(olTimer),
    .settingAck(ack),
    .settingRefused(refused),
    .compFreq(compFreq),
    .regenActive(active),
    .stallPrevention(stall),
    .overloadAlarmSignal(alarm),
    .regenAvoidSelect(mode),
    .regenAvoidLevel(level),
    .compFreqLimit(limit),
    .voltageResponseGain(vGain),
    .frequencyResponseGain(fGain)
  );

  rafc_drive_model drv
  (
    .mclk(mclk),
    .resetn(resetn),
    .target(target),
    .rise(rise),
    .drive(drive)
  );

  // ------------------
  // helpers
  // ------------------
  task automatic chk16(string nm, logic [15:0] e, logic [15:0] g);
    compares++;
    if (g !== e)
    begin
      numErrors++;
      $display("[FAIL] %s exp=%h got=%h", nm, e, g);
    end
  endtask

  task automatic chkB(string nm, logic e, logic g);
    compares++;
    if (g !== e)
    begin
      numErrors++;
      $display("[FAIL] %s exp=%b got=%b", nm, e, g);
    end
  endtask

  function automatic logic [15:0] regVal(logic [2:0] s);
    case (s)
      3'h0: return {14'h0000, mode};
      3'h1: return {6'h00, level};
      3'h2: return limit;
      3'h3: return {8'h00, vGain};
      3'h4: return {8'h00, fGain};
      default: return 16'h0000;
    endcase
  endfunction

  task automatic cyc(int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic doRst(logic hv, logic [15:0] lvl);
    hvClass = hv;
    resetn = 1'b0;
    cyc(8);
    resetn = 1'b1;
    cyc(1);
    chk16("mode", 16'h0000, regVal(3'h0));
    chk16("level", lvl, regVal(3'h1));
    chk16("limit", 16'h0258, limit);
    chk16("vgain", 16'h0064, regVal(3'h3));
    chk16("fgain", 16'h0064, regVal(3'h4));
    chkB("active", 1'b0, active);
  endtask

  // one idle cycle between writes keeps valid from being set twice
  task automatic wrSet(logic [2:0] s, logic [15:0] d);
    @(negedge mclk);
    wr = '{1'b1, s, d};
    @(negedge mclk);
    wr.valid = 1'b0;
  endtask

  task automatic rate(logic [7:0] vg, logic [7:0] fg, logic [15:0] d);
    wrSet(3'h3, {8'h00, vg});
    wrSet(3'h4, {8'h00, fg});
    cyc(8);
    c0 = compFreq;
    cyc(40);
    chk16("rate", c0 + d, compFreq);
  endtask

  task automatic summarize();
    $display("errors=%0d compares=%0d", numErrors, compares);
    if (numErrors == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  initial
  begin
    #500000;
    numErrors++;
    summarize();
  end

  // ------------------
  // main sequence
  // ------------------
  initial
  begin
    numErrors = 0;
    compares = 0;
    wr = '0;
    vis = 1'b0;
    maxFreq = 16'hffff;
    olTimer = 8'h01;
    olOther = 1'b0;
    target = 16'h03e8;
    rise = 10'h000;
    doRst(1'b0, 16'h0190);
    foreach (rows[i])
    begin
      @(negedge mclk);
      vis = rows[i].vis;
      wr = '{1'b1, rows[i].sel, rows[i].data};
      #1;
      chkB("ack", rows[i].ack, ack);
      chkB("refused", !rows[i].ack, refused);
      @(negedge mclk);
      wr.valid = 1'b0;
      vis = 1'b0;
      chk16("setting", rows[i].val, regVal(rows[i].sel));
    end
    cyc(60);
    rise = 10'h027;
    cyc(3);
    chkB("atLevel", 1'b1, active);
    rise = 10'h026;
    cyc(3);
    chkB("belowLevel", 1'b0, active);
    rise = 10'h064;
    for (int m = 0; m < 3; m++)
    begin
      wrSet(3'h0, 16'(m));
      target = 16'h05dc;
      cyc(3);
      chkB("accel", m == 1, active);
      cyc(60);
      chkB("const", m != 0, active);
      target = 16'h03e8;
      cyc(3);
      chkB("decel", m == 1, active);
      cyc(60);
    end
    wrSet(3'h0, 16'h0001);
    cyc(60);
    chk16("cap", 16'h0640, compFreq);
    chkB("stall", 1'b1, stall);
    maxFreq = 16'h0514;
    cyc(2);
    chk16("max", 16'h0514, compFreq);
    maxFreq = 16'hffff;
    target = 16'h0000;
    rise = 10'h000;
    cyc(40);
    c0 = drive.preFreq;
    cyc(1);
    chk16("hold", c0 + 16'h0258, compFreq);
    cyc(100);
    chkB("release", compFreq < 16'h0258, 1'b1);
    wrSet(3'h2, 16'h270f);
    target = 16'h03e8;
    rise = 10'h031;
    cyc(110);
    rate(8'hc8, 8'h64, 16'h00c8);
    rate(8'hc8, 8'h32, 16'h0064);
    rate(8'h00, 8'h64, 16'h000a);
    rise = 10'h000;
    cyc(4);
    chkB("olIdle", 1'b0, alarm);
    rise = 10'h031;
    cyc(380);
    chkB("olEarly", 1'b0, alarm);
    cyc(40);
    chkB("olSet", 1'b1, alarm);
    rise = 10'h000;
    cyc(3);
    chkB("olClear", 1'b0, alarm);
    // other overload items alone must also run through the timer
    olOther = 1'b1;
    cyc(3);
    chkB("olOtherEarly", 1'b0, alarm);
    cyc(410);
    chkB("olOtherSet", 1'b1, alarm);
    olOther = 1'b0;
    cyc(3);
    chkB("olOtherClear", 1'b0, alarm);
    doRst(1'b1, 16'h030c);
    summarize();
  end
endmodule

`default_nettype wire
